// File: src/pswc_defs.vh
// Purpose: Constants for the power state and wake control block
// Assumes: Included by pswc_top.v only
// Notes: Offsets are APB byte addresses
`ifndef PSWC_DEFS_VH
`define PSWC_DEFS_VH
// Register offsets
`define PSWC_PM_CTRL 8'h00
`define PSWC_CFG 8'h04
`define PSWC_WAKE_CAUSE 8'h08
`define PSWC_BAR_STAT 8'h0C
`define PSWC_STA_LO 8'h10
`define PSWC_STA_HI 8'h14
`define PSWC_BUF_IDX 8'h18
`define PSWC_BUF_DATA 8'h1C
// Field positions
`define PSWC_PME_EN_BIT 8
`define PSWC_PME_ST_BIT 15
`define PSWC_CFG_GATE_BIT 0
`define PSWC_CFG_MGMT_BIT 1
`define PSWC_CAUSE_LINK 0
`define PSWC_CAUSE_PKT 1
`define PSWC_CAUSE_SENT 2
`define PSWC_CAUSE_MGMT 3
// Power states
`define PSWC_D0 2'h0
`define PSWC_D1 2'h1
`define PSWC_D2 2'h2
`define PSWC_D3 2'h3
// Wake buffer and sentinel
`define PSWC_WAKE_BYTES 128
`define PSWC_SENT_FF 6
`define PSWC_SENT_REP 16
`define PSWC_ADDR_BYTES 6
`endif

// File: src/pswc_top.v
// Purpose: Power state, internal init and wake event control
// Assumes: All inputs synchronous to pclk; receive bytes pre-framed
// Notes: Wake buffer read back through index and data registers
`timescale 1ns/100ps
`include "pswc_defs.vh"

module pswc_top #(
    parameter WAKE_BYTES = `PSWC_WAKE_BYTES
) (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // APB slave
    input wire [7:0] paddr,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire pready,
    output wire pslverr,
    // Power and bus pins
    input wire pci_rst_n,
    input wire isolate_n,
    input wire alt_power_on_reset_n,
    input wire aux_power_present,
    input wire cardbus_mode,
    // Link and receive stream
    input wire link_valid,
    input wire rx_valid,
    input wire rx_sof,
    input wire rx_eof,
    input wire [7:0] rx_byte,
    input wire rx_pattern_hit,
    input wire rx_mgmt_hit,
    input wire smbus_present,
    // Control outputs
    output wire internal_init,
    output wire pci_out_en,
    output wire pci_in_en,
    output wire full_func,
    output wire cfg_only,
    output wire link_integrity_en,
    output wire mgmt_fwd,
    // Event outputs
    output wire pme_o,
    output wire pme_oe,
    output wire cstschg
);

localparam integer SENT_LEN = `PSWC_SENT_FF + `PSWC_SENT_REP * `PSWC_ADDR_BYTES;
localparam integer SENT_FF = `PSWC_SENT_FF;
localparam [6:0] SENT_LEN7 = SENT_LEN[6:0];
localparam [6:0] SENT_FF7 = SENT_FF[6:0];
localparam [7:0] WAKE8 = WAKE_BYTES[7:0];

//------------------------------------------------------------
// Functions
//------------------------------------------------------------
// Station address byte select
function [7:0] pswc_sel_byte;
    input [47:0] a;
    input [2:0] i;
    begin
        case (i)
            3'h0: pswc_sel_byte = a[7:0];
            3'h1: pswc_sel_byte = a[15:8];
            3'h2: pswc_sel_byte = a[23:16];
            3'h3: pswc_sel_byte = a[31:24];
            3'h4: pswc_sel_byte = a[39:32];
            default: pswc_sel_byte = a[47:40];
        endcase
    end
endfunction

// Address map decode
function pswc_mapped;
    input [7:0] a;
    begin
        pswc_mapped = (a[1:0] == 2'h0) && (a[7:5] == 3'h0);
    end
endfunction

//------------------------------------------------------------
// State
//------------------------------------------------------------
reg [1:0] dstate_ff;
reg pme_en_ff;
reg [3:0] cause_ff;
reg [7:0] wlen_ff;
reg [1:0] cfg_ff;
reg [47:0] sta_ff;
reg [6:0] bidx_ff;
reg d0a_ff;
reg aux_ff;
reg b0_ff;
reg rst_prev_ff;
reg iso_prev_ff;
reg link_prev_ff;
reg init_q_ff;
reg init_ff;
reg por_ff;
reg [7:0] bcnt_ff;
reg hit_ff;
reg mhit_ff;
reg [6:0] sc_ff;
reg [2:0] ai_ff;
reg sent_ff;
reg pready_ff;
reg [31:0] prdata_ff;
reg pslverr_ff;
reg pci_oe_ff;
reg pci_in_ff;
reg full_ff;
reg cfgo_ff;
reg link_int_ff;
reg mgmt_fwd_ff;
reg pme_o_ff;
reg pme_oe_ff;
reg cstschg_ff;
reg [7:0] wbuf [0:WAKE_BYTES-1];

//------------------------------------------------------------
// Init conditions
//------------------------------------------------------------
wire is_d0 = (dstate_ff == `PSWC_D0);
wire is_d3 = (dstate_ff == `PSWC_D3);
// Reset honoured only when not isolated and no aux power
wire eff_rst = ~pci_rst_n & isolate_n & ~aux_ff;
wire rst_trail = pci_rst_n & ~rst_prev_ff & isolate_n;
wire iso_trail = isolate_n & ~iso_prev_ff;
wire init_cond = (eff_rst & ~is_d3)
    | (rst_trail & ~aux_ff & is_d3)
    | iso_trail | ~alt_power_on_reset_n;
// Event context survives unless events off outside D3, or power-on reset
wire keep = (pme_en_ff | is_d3) & ~por_ff;
wire wipe = init_ff & ~keep;

//------------------------------------------------------------
// APB decode
//------------------------------------------------------------
wire setup = psel & ~penable;
wire wr = psel & penable & pwrite & pready_ff & ~init_ff;
wire wr_pm = wr & (paddr == `PSWC_PM_CTRL);
wire wr_cfg = wr & (paddr == `PSWC_CFG);
wire wr_cause = wr & (paddr == `PSWC_WAKE_CAUSE);
wire wr_bar = wr & (paddr == `PSWC_BAR_STAT);
wire wr_slo = wr & (paddr == `PSWC_STA_LO);
wire wr_shi = wr & (paddr == `PSWC_STA_HI);
wire wr_idx = wr & (paddr == `PSWC_BUF_IDX);

//------------------------------------------------------------
// Receive classification
//------------------------------------------------------------
wire rx_take = rx_valid & ~init_ff;
wire rx_end = rx_take & rx_eof;
wire [7:0] cnt_b = rx_sof ? 8'h00 : bcnt_ff;
wire in_win = (cnt_b < WAKE8);
// Packet wake only low power, events on, link valid
wire lowpwr = ~is_d0 & pme_en_ff & link_valid;
wire lock = cause_ff[`PSWC_CAUSE_PKT];
wire n_hit = (~rx_sof & hit_ff) | (rx_pattern_hit & in_win);
wire n_mhit = (~rx_sof & mhit_ff) | rx_mgmt_hit;
wire mgmt_wake = n_mhit & ~smbus_present;
wire wake_pkt = n_hit | mgmt_wake;
reg [6:0] nxt_sc;
reg [2:0] nxt_ai;
reg nxt_sent;
reg [6:0] sc_b;
reg [2:0] ai_b;
reg [7:0] exp_b;

// Sentinel detector across the whole frame
always @* begin
    sc_b = rx_sof ? 7'h00 : sc_ff;
    ai_b = rx_sof ? 3'h0 : ai_ff;
    nxt_sent = ~rx_sof & sent_ff;
    exp_b = (sc_b < SENT_FF7) ? 8'hFF : pswc_sel_byte(sta_ff, ai_b);
    nxt_ai = 3'h0;
    if (rx_byte == exp_b) begin
        nxt_sc = sc_b + 7'h01;
        if (sc_b >= SENT_FF7 && ai_b != 3'h5) begin
            nxt_ai = ai_b + 3'h1;
        end
        if (nxt_sc == SENT_LEN7) begin
            nxt_sent = 1'b1;
            nxt_sc = 7'h00;
        end
    end else if (rx_byte == 8'hFF) begin
        nxt_sc = SENT_FF7;
    end else begin
        nxt_sc = 7'h00;
    end
end

//------------------------------------------------------------
// Wake cause next value
//------------------------------------------------------------
wire link_chg = (link_valid ^ link_prev_ff) & ~init_ff;
wire ev_ok = pme_en_ff;
reg [3:0] set_c;
always @* begin
    set_c = 4'h0;
    set_c[`PSWC_CAUSE_LINK] = link_chg & ev_ok;
    set_c[`PSWC_CAUSE_PKT] = rx_end & lowpwr & wake_pkt;
    set_c[`PSWC_CAUSE_SENT] = rx_end & lowpwr & nxt_sent;
    set_c[`PSWC_CAUSE_MGMT] = rx_end & lowpwr & mgmt_wake;
end
wire [3:0] clr_c = wr_cause ? pwdata[3:0] : 4'h0;
// Set wins over a clear in the same cycle
wire [3:0] nxt_cause = (cause_ff & ~clr_c) | set_c;
wire pme_act = (|cause_ff) & pme_en_ff & cfg_ff[`PSWC_CFG_GATE_BIT];

//------------------------------------------------------------
// Bus pin sampling and init generation
//------------------------------------------------------------
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        rst_prev_ff <= 1'b0;
        iso_prev_ff <= 1'b0;
        link_prev_ff <= 1'b0;
        init_q_ff <= 1'b1;
        init_ff <= 1'b1;
        por_ff <= 1'b1;
        aux_ff <= 1'b0;
        b0_ff <= 1'b0;
    end else begin
        rst_prev_ff <= pci_rst_n;
        iso_prev_ff <= isolate_n;
        link_prev_ff <= link_valid;
        init_q_ff <= init_cond;
        init_ff <= init_cond | init_q_ff;
        if (!alt_power_on_reset_n) begin
            por_ff <= 1'b1;
        end else if (!init_ff) begin
            por_ff <= 1'b0;
        end
        if (!pci_rst_n || !alt_power_on_reset_n) begin
            aux_ff <= aux_power_present;
        end
        if (!isolate_n) begin
            b0_ff <= 1'b0;
        end else if (rst_trail) begin
            b0_ff <= 1'b1;
        end
    end
end

//------------------------------------------------------------
// Registers cleared by internal init, except the event gate bit kept with the event context
//------------------------------------------------------------
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        cfg_ff <= 2'h0;
        sta_ff <= 48'h0;
        bidx_ff <= 7'h00;
        d0a_ff <= 1'b0;
        bcnt_ff <= 8'h00;
        hit_ff <= 1'b0;
        mhit_ff <= 1'b0;
        sc_ff <= 7'h00;
        ai_ff <= 3'h0;
        sent_ff <= 1'b0;
    end else if (init_ff) begin
        // Event gate survives with the event context
        cfg_ff <= {1'b0, cfg_ff[`PSWC_CFG_GATE_BIT] & keep};
        sta_ff <= 48'h0;
        bidx_ff <= 7'h00;
        d0a_ff <= 1'b0;
        bcnt_ff <= 8'h00;
        hit_ff <= 1'b0;
        mhit_ff <= 1'b0;
        sc_ff <= 7'h00;
        ai_ff <= 3'h0;
        sent_ff <= 1'b0;
    end else begin
        if (wr_cfg) begin
            cfg_ff <= pwdata[1:0];
        end
        if (wr_slo) begin
            sta_ff[31:0] <= pwdata;
        end
        if (wr_shi) begin
            sta_ff[47:32] <= pwdata[15:0];
        end
        if (wr_idx) begin
            bidx_ff <= pwdata[6:0];
        end
        if (wr_bar) begin
            d0a_ff <= 1'b1;
        end
        if (rx_take) begin
            bcnt_ff <= (cnt_b == 8'hFF) ? cnt_b : cnt_b + 8'h01;
            // Frame end drops hit and sentinel state; byte count restarts at the next start of frame
            hit_ff <= n_hit & ~rx_eof;
            mhit_ff <= n_mhit & ~rx_eof;
            sc_ff <= rx_eof ? 7'h00 : nxt_sc;
            ai_ff <= rx_eof ? 3'h0 : nxt_ai;
            sent_ff <= nxt_sent & ~rx_eof;
        end
    end
end

//------------------------------------------------------------
// Power management context
//------------------------------------------------------------
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        dstate_ff <= `PSWC_D0;
        pme_en_ff <= 1'b0;
        cause_ff <= 4'h0;
        wlen_ff <= 8'h00;
    end else if (wipe) begin
        dstate_ff <= `PSWC_D0;
        pme_en_ff <= 1'b0;
        cause_ff <= 4'h0;
        wlen_ff <= 8'h00;
    end else if (!init_ff) begin
        if (wr_pm) begin
            dstate_ff <= pwdata[1:0];
            pme_en_ff <= pwdata[`PSWC_PME_EN_BIT];
        end
        cause_ff <= nxt_cause;
        if (set_c[`PSWC_CAUSE_PKT] && !lock) begin
            wlen_ff <= in_win ? cnt_b + 8'h01 : WAKE8;
        end
    end
end

// Wake buffer capture, first bytes only, frozen once a packet wake is kept
always @(posedge pclk) begin
    if (rx_take && lowpwr && in_win && !lock) begin
        wbuf[cnt_b[6:0]] <= rx_byte;
    end
end

//------------------------------------------------------------
// APB slave, zero wait, registered answer
//------------------------------------------------------------
reg [31:0] rd_mux;
always @* begin
    rd_mux = 32'h0;
    case (paddr)
        `PSWC_PM_CTRL: rd_mux = {16'h0, |cause_ff, 6'h0, pme_en_ff, 6'h0, dstate_ff};
        `PSWC_CFG: rd_mux = {30'h0, cfg_ff};
        `PSWC_WAKE_CAUSE: rd_mux = {16'h0, wlen_ff, 4'h0, cause_ff};
        `PSWC_BAR_STAT: rd_mux = {28'h0, b0_ff, aux_ff, link_valid, d0a_ff};
        `PSWC_STA_LO: rd_mux = sta_ff[31:0];
        `PSWC_STA_HI: rd_mux = {16'h0, sta_ff[47:32]};
        `PSWC_BUF_IDX: rd_mux = {25'h0, bidx_ff};
        `PSWC_BUF_DATA: rd_mux = {24'h0, wbuf[bidx_ff]};
        default: rd_mux = 32'h0;
    endcase
end

// Answer prepared in setup, valid through the access phase
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        pready_ff <= 1'b0;
        prdata_ff <= 32'h0;
        pslverr_ff <= 1'b0;
    end else begin
        pready_ff <= setup;
        if (setup) begin
            prdata_ff <= pwrite ? 32'h0 : rd_mux;
            pslverr_ff <= ~pswc_mapped(paddr);
        end
    end
end

//------------------------------------------------------------
// Pin control and function mode outputs
//------------------------------------------------------------
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        pci_oe_ff <= 1'b0;
        pci_in_ff <= 1'b0;
        full_ff <= 1'b0;
        cfgo_ff <= 1'b0;
        link_int_ff <= 1'b0;
        mgmt_fwd_ff <= 1'b0;
        pme_o_ff <= 1'b0;
        pme_oe_ff <= 1'b0;
        cstschg_ff <= 1'b0;
    end else begin
        pci_oe_ff <= pci_rst_n & isolate_n;
        pci_in_ff <= pci_rst_n & isolate_n;
        full_ff <= is_d0 & d0a_ff & ~init_ff;
        cfgo_ff <= ~is_d0;
        if (is_d0) begin
            link_int_ff <= 1'b1;
        end else if (!pme_en_ff) begin
            link_int_ff <= cfg_ff[`PSWC_CFG_MGMT_BIT] & link_valid;
        end else if (dstate_ff == `PSWC_D1) begin
            link_int_ff <= 1'b1;
        end else begin
            link_int_ff <= link_valid;
        end
        mgmt_fwd_ff <= rx_end & n_mhit & smbus_present;
        pme_o_ff <= 1'b0;
        // Event pin stays live while isolated
        pme_oe_ff <= pme_act & ~cardbus_mode;
        cstschg_ff <= pme_act & cardbus_mode;
    end
end

// Output wiring
assign prdata = prdata_ff;
assign pready = pready_ff;
assign pslverr = pslverr_ff;
assign internal_init = init_ff;
assign pci_out_en = pci_oe_ff;
assign pci_in_en = pci_in_ff;
assign full_func = full_ff;
assign cfg_only = cfgo_ff;
assign link_integrity_en = link_int_ff;
assign mgmt_fwd = mgmt_fwd_ff;
assign pme_o = pme_o_ff;
assign pme_oe = pme_oe_ff;
assign cstschg = cstschg_ff;

endmodule // pswc_top

// File: test/pswc_chk_sva.sv
// Purpose: Port level checks for the power state and wake block
// Assumes: One pclk domain, presetn asynchronous active low
// Notes: Attached to pswc_top by the bind at the foot
`timescale 1ns/100ps
module pswc_chk #(
    parameter WAKE_BYTES = 128
) (
    // Clock, reset and APB
    input wire pclk,
    input wire presetn,
    input wire [7:0] paddr,
    input wire psel,
    input wire penable,
    input wire pready,
    input wire pslverr,
    // Power pins
    input wire pci_rst_n,
    input wire isolate_n,
    input wire alt_power_on_reset_n,
    // Receive side and outputs
    input wire rx_valid,
    input wire rx_eof,
    input wire smbus_present,
    input wire internal_init,
    input wire pci_out_en,
    input wire pci_in_en,
    input wire mgmt_fwd,
    input wire pme_o,
    input wire pme_oe,
    input wire cstschg
);
    // ------------------------------
    // Checks
    // ------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    AST_APB_READY: assert property (psel && !penable |=> pready)
        else $error("pready late");
    AST_APB_ONE: assert property (pready |=> !pready)
        else $error("pready stuck");
    AST_SLVERR: assert property (psel && !penable && (paddr > 8'h1C || paddr[1:0] != 2'h0)
        |=> pready && pslverr) else $error("no slave error");
    AST_RST_FLOAT: assert property (!pci_rst_n |=> !pci_out_en && !pci_in_en)
        else $error("pins driven in reset");
    AST_ISO_FLOAT: assert property (!isolate_n |=> !pci_in_en)
        else $error("inputs honoured when isolated");
    AST_PINS_ON: assert property (pci_rst_n && isolate_n |=> pci_out_en)
        else $error("pins not driven in B0");
    AST_ISO_INIT: assert property ($rose(isolate_n) |=> internal_init)
        else $error("no init on isolate release");
    AST_ALT_HOLD: assert property (!alt_power_on_reset_n ##1 alt_power_on_reset_n
        |=> internal_init) else $error("init not held");
    AST_PME_PIN: assert property (!pme_o && !(pme_oe && cstschg))
        else $error("event on both pins");
    AST_MGMT: assert property (mgmt_fwd |-> $past(rx_eof) && $past(rx_valid)
        && $past(smbus_present)) else $error("stray forward pulse");
endmodule // pswc_chk

bind pswc_top pswc_chk #(.WAKE_BYTES(WAKE_BYTES)) u_chk (.pclk(pclk), .presetn(presetn),
    .paddr(paddr), .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
    .pci_rst_n(pci_rst_n), .isolate_n(isolate_n),
    .alt_power_on_reset_n(alt_power_on_reset_n), .rx_valid(rx_valid), .rx_eof(rx_eof),
    .smbus_present(smbus_present), .internal_init(internal_init), .pci_out_en(pci_out_en),
    .pci_in_en(pci_in_en), .mgmt_fwd(mgmt_fwd), .pme_o(pme_o), .pme_oe(pme_oe),
    .cstschg(cstschg));

// File: test/pswc_host_model.sv
// Purpose: Host power manager driving PCI reset and power good
// Assumes: Pins change just after a rising pclk edge
// Notes: Tasks are called from the testbench
`timescale 1ns/100ps
module pswc_host_model (
    // Clock
    input wire pclk,
    // Power pins
    output logic pci_rst_n,
    output logic isolate_n
);
    // Bus starts powered, reset released
    initial begin
        pci_rst_n = 1'b1;
        isolate_n = 1'b1;
    end
    // Drive the reset level
    task rst(input logic v);
        @(posedge pclk);
        pci_rst_n <= v;
    endtask
    // Bus off: power good and reset both low
    task b3;
        @(posedge pclk);
        pci_rst_n <= 1'b0;
        isolate_n <= 1'b0;
    endtask
    // Bus on: power good first, reset trails
    task b0;
        @(posedge pclk);
        isolate_n <= 1'b1;
        repeat (3) @(posedge pclk);
        pci_rst_n <= 1'b1;
    endtask
endmodule // pswc_host_model

// File: test/test_power_state_wake_control.sv
// Purpose: Self-checking bench for the power state and wake block
// Assumes: Host model owns PCI reset and power good
// Notes: APB reads leave data in rd and error in er
`timescale 1ns/100ps
module test_power_state_wake_control;
    logic pclk, presetn, psel, penable, pwrite, alt_n, aux, cbm, link;
    logic rxv, sof, eof, phit, mhit, smb, er;
    logic [7:0] paddr, rxb;
    logic [31:0] pwdata, rd;
    wire [31:0] prdata;
    wire pready, pslverr, pci_rst_n, isolate_n, init, oen, ien, ffn, cfo, mfw, pme_oe, cst;
    wire lie, pmo;
    int mismatches, checked;

    // Design and host
    pswc_top i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pci_rst_n(pci_rst_n), .isolate_n(isolate_n),
        .alt_power_on_reset_n(alt_n), .aux_power_present(aux), .cardbus_mode(cbm),
        .link_valid(link), .rx_valid(rxv), .rx_sof(sof), .rx_eof(eof), .rx_byte(rxb),
        .rx_pattern_hit(phit), .rx_mgmt_hit(mhit), .smbus_present(smb),
        .internal_init(init), .pci_out_en(oen), .pci_in_en(ien), .full_func(ffn),
        .cfg_only(cfo), .link_integrity_en(lie), .mgmt_fwd(mfw), .pme_o(pmo),
        .pme_oe(pme_oe), .cstschg(cst));
    pswc_host_model u_host (.pclk(pclk), .pci_rst_n(pci_rst_n), .isolate_n(isolate_n));

    // ------------------------------
    // Helpers
    // ------------------------------
    task chk(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            $display("[ERR] %0t got %h exp %h", $time, g, e);
            mismatches++;
        end
    endtask
    task cyc(input int n);
        repeat (n) @(negedge pclk);
    endtask
    // One APB transfer, held until pready
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Wait for the answer; only the watchdog ends a hang
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task waitv(input logic v);
        int n;
        n = 0;
        do begin
            @(negedge pclk);
            n++;
        end while (init !== v && n < 40);
        chk(init, v);
    endtask
    task cause(input logic [31:0] e);
        apb(1'b0, 8'h08, 32'h0);
        chk(rd & 32'hF, e);
    endtask
    task clr;
        apb(1'b1, 8'h08, 32'hF);
    endtask
    // Frame of n bytes, filter hit at byte hit
    task frm(input int n, input int hit, input logic mg, input logic sn);
        for (int i = 0; i < n; i++) begin
            @(posedge pclk);
            rxv <= 1'b1;
            sof <= (i == 0);
            eof <= (i == n - 1);
            rxb <= sn ? (i < 6 ? 8'hFF : 8'(((i - 6) % 6 + 1) * 17)) : 8'(i);
            phit <= (i == hit);
            mhit <= mg;
        end
        @(posedge pclk);
        rxv <= 1'b0;
        sof <= 1'b0;
        eof <= 1'b0;
        phit <= 1'b0;
        mhit <= 1'b0;
    endtask

    // ------------------------------
    // Scenarios
    // ------------------------------
    task t_apb;
        apb(1'b0, 8'h00, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 8'h20, 32'h0);
        chk({31'h0, er}, 32'h1);
        apb(1'b0, 8'h0C, 32'h0);
        chk(rd & 32'h1, 32'h0);
        apb(1'b1, 8'h0C, 32'h1);
        apb(1'b0, 8'h0C, 32'h0);
        chk(rd & 32'h1, 32'h1);
        cyc(2);
        chk(ffn, 1'b1);
        $display("t_apb done");
    endtask
    task t_init;
        apb(1'b1, 8'h04, 32'h3);
        u_host.rst(1'b0);
        cyc(3);
        chk(init, 1'b1);
        chk(oen, 1'b0);
        u_host.rst(1'b1);
        waitv(1'b0);
        apb(1'b0, 8'h04, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 8'h0C, 32'h0);
        chk(rd & 32'h1, 32'h0);
        $display("t_init done");
    endtask
    task t_link;
        apb(1'b1, 8'h04, 32'h1);
        apb(1'b1, 8'h00, 32'h100);
        @(posedge pclk) link <= 1'b0;
        cyc(4);
        chk(pme_oe, 1'b1);
        chk(cst, 1'b0);
        chk(pmo, 1'b0);
        chk(lie, 1'b1);
        @(posedge pclk) cbm <= 1'b1;
        cyc(3);
        chk(cst, 1'b1);
        chk(pme_oe, 1'b0);
        @(posedge pclk) cbm <= 1'b0;
        apb(1'b1, 8'h04, 32'h0);
        cyc(3);
        chk(pme_oe, 1'b0);
        clr;
        apb(1'b1, 8'h00, 32'h0);
        @(posedge pclk) link <= 1'b1;
        cyc(3);
        cause(32'h0);
        $display("t_link done");
    endtask
    task t_pkt;
        apb(1'b1, 8'h00, 32'h101);
        apb(1'b1, 8'h04, 32'h1);
        apb(1'b1, 8'h10, 32'h44332211);
        apb(1'b1, 8'h14, 32'h6655);
        cyc(2);
        chk(cfo, 1'b1);
        chk(lie, 1'b1);
        frm(140, 3, 1'b0, 1'b0);
        cause(32'h2);
        chk(rd & 32'hFF00, 32'h8000);
        chk(pme_oe, 1'b1);
        apb(1'b1, 8'h18, 32'h5);
        apb(1'b0, 8'h1C, 32'h0);
        chk(rd & 32'hFF, 32'h5);
        clr;
        frm(140, 130, 1'b0, 1'b0);
        cause(32'h0);
        frm(120, 200, 1'b0, 1'b1);
        cause(32'h4);
        clr;
        @(posedge pclk) smb <= 1'b1;
        frm(20, 200, 1'b1, 1'b0);
        cyc(1);
        chk(mfw, 1'b1);
        cause(32'h0);
        @(posedge pclk) smb <= 1'b0;
        frm(20, 200, 1'b1, 1'b0);
        cause(32'hA);
        clr;
        apb(1'b1, 8'h00, 32'h2);
        apb(1'b1, 8'h04, 32'h2);
        cyc(2);
        chk(lie, 1'b1);
        apb(1'b1, 8'h04, 32'h0);
        cyc(2);
        chk(lie, 1'b0);
        apb(1'b1, 8'h00, 32'h0);
        $display("t_pkt done");
    endtask
    task t_d3;
        apb(1'b1, 8'h04, 32'h1);
        apb(1'b1, 8'h00, 32'h103);
        @(posedge pclk) link <= 1'b0;
        cyc(4);
        chk(lie, 1'b0);
        u_host.b3;
        cyc(3);
        chk(ien, 1'b0);
        chk(pme_oe, 1'b1);
        u_host.b0;
        cyc(10);
        u_host.rst(1'b0);
        cyc(3);
        chk(init, 1'b0);
        u_host.rst(1'b1);
        waitv(1'b1);
        waitv(1'b0);
        chk(pme_oe, 1'b1);
        apb(1'b0, 8'h00, 32'h0);
        chk(rd & 32'h103, 32'h103);
        cause(32'h1);
        @(posedge pclk) link <= 1'b1;
        cyc(3);
        clr;
        apb(1'b1, 8'h00, 32'h0);
        $display("t_d3 done");
    endtask
    task t_aux;
        @(posedge pclk) begin
            aux <= 1'b1;
            alt_n <= 1'b0;
        end
        cyc(3);
        chk(init, 1'b1);
        @(posedge pclk) alt_n <= 1'b1;
        waitv(1'b0);
        apb(1'b0, 8'h0C, 32'h0);
        chk(rd & 32'h4, 32'h4);
        u_host.rst(1'b0);
        cyc(3);
        chk(init, 1'b0);
        u_host.rst(1'b1);
        cyc(3);
        chk(init, 1'b0);
        $display("t_aux done");
    endtask
    task give_verdict;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // ------------------------------
    // Clock, sequence and watchdog
    // ------------------------------
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    // Run takes under a thousand cycles; the watchdog allows 20000
    initial begin
        #100000;
        mismatches++;
        give_verdict;
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, aux, cbm} = '0;
        {rxv, sof, eof, rxb, phit, mhit, smb} = '0;
        alt_n = 1'b1;
        link = 1'b1;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        waitv(1'b0);
        t_apb;
        t_init;
        t_link;
        t_pkt;
        t_d3;
        t_aux;
        give_verdict;
    end
endmodule // test_power_state_wake_control
